// ### rtl/mxb_ext_bus.sv
// External memory, data bus, port and expander bus interface
//
// Overview of operation
// [RQ1] One address-latch pulse in every machine cycle.
// [RQ2] Fetch drives low PC byte with latch pulse, reads code on fetch strobe.
// [RQ3] Upper four PC bits on port two low pins during external fetch.
// [RQ4] Data memory: address with latch pulse, then read or write strobe.
// [RQ5] Read strobe for external data read and bus input instructions.
// [RQ6] Write strobe for external data write and bus output instructions.
// [RQ7] Bus lines bidirectional; output data held in a latch.
// [RQ8] External code select high means code is fetched externally.
// [RQ9] Ports quasi-bidirectional, reset to all ones, input after ones written.
// [RQ10] Port two low nibble is expander bus framed by expander strobe.
// [RQ11] Test pin a sampled by jumps, or outputs internal clock when enabled.
// [RQ12] Test pin b sampled by jumps, or counts events when counting started.
// [RQ13] Interrupt pin is a jump condition and an interrupt request.
// [RQ14] Single-step input halts after each instruction, with latch pulse. Here ale stays low while halted.
// [RQ15] External latch captures low address at latch strobe fall.
// [RQ16] Program memory drives bus only while fetch strobe is low.
// [RQ17] Read, write, fetch, reset active low; latch, expander strobes high. Here the reset input is active high.
`timescale 1ns/1ps
`default_nettype none
module mxb_ext_bus #(
   parameter int unsigned PC_W = 12
) (
   // Clock and reset
   input  wire logic            ref_clk,
   input  wire logic            reset,
   // Core requests, held for the machine cycle they apply to
   input  wire logic [PC_W-1:0] core_pc,
   input  wire logic [2:0]      core_op,
   input  wire logic [7:0]      core_addr,
   input  wire logic [7:0]      core_wdata,
   input  wire logic [3:0]      core_exp_ctl,
   input  wire logic            core_instr_end,
   input  wire logic            port_one_wr,
   input  wire logic [7:0]      port_one_wdata,
   input  wire logic            port_two_wr,
   input  wire logic [7:0]      port_two_wdata,
   input  wire logic            clock_out_enable_instr,
   input  wire logic            start_event_count_instr,
   input  wire logic            stop_event_count_instr,
   // Core results
   output logic [7:0]           core_rdata,
   output logic                 core_rdata_vld,
   output logic                 cycle_start,
   output logic                 core_stall,
   output logic                 jump_on_test_a,
   output logic                 jump_on_test_b,
   output logic                 jump_on_irq_pin,
   output logic                 irq_req,
   output logic                 event_tick,
   output logic [7:0]           port_one_in,
   output logic [7:0]           port_two_in,
   // Straps and control pins
   input  wire logic            external_code_select,
   input  wire logic            single_step_n,
   input  wire logic            irq_pin_n,
   // Strobes
   output logic                 ale,
   output logic                 prog_fetch_strobe_n,
   output logic                 rd_n,
   output logic                 wr_n,
   output logic                 exp_strobe,
   // Bus lines
   input  wire logic [7:0]      bus_lines_i,
   output logic [7:0]           bus_lines_o,
   output logic                 bus_lines_oe,
   // Quasi-bidirectional ports
   input  wire logic [7:0]      port_one_i,
   output logic [7:0]           port_one_o,
   output logic [7:0]           port_one_oe,
   input  wire logic [7:0]      port_two_i,
   output logic [7:0]           port_two_o,
   output logic [7:0]           port_two_oe,
   // Test pins
   input  wire logic            test_pin_a_i,
   output logic                 test_pin_a_o,
   output logic                 test_pin_a_oe,
   input  wire logic            test_pin_b
);
   logic [3:0]             phase_q;
   mxb_pkg::mxb_op_t       op_q;
   mxb_pkg::mxb_state_t    state_q;
   logic [PC_W-1:0]        pc_q;
   logic [7:0]             addr_q;
   logic [7:0]             out_latch_q;
   logic [3:0]             exp_ctl_q;
   logic [7:0]             p1_latch_q;
   logic [7:0]             p2_latch_q;
   logic                   ext_q;
   logic                   clk_out_en_q;
   logic [1:0]             div_q;
   logic                   clk_out_q;
   logic                   count_en_q;
   logic                   tb_q;
   logic                   step_q;

   // Strobe window test reused by every strobe
   function automatic logic in_win(input logic [3:0] ph,
                                   input logic [3:0] lo,
                                   input logic [3:0] hi);
      in_win = (ph >= lo) && (ph < hi);
   endfunction

   wire logic last_ph   = (phase_q == mxb_pkg::PH_LAST);
   wire logic strobe_ph = in_win(phase_q, mxb_pkg::PH_STB_ON,
                                 mxb_pkg::PH_STB_OFF);
   wire logic addr_ph   = in_win(phase_q, mxb_pkg::PH_ALE_ON,
                                 mxb_pkg::PH_ADDR_OFF);
   wire logic is_rd     = (op_q == mxb_pkg::MXB_OP_XRD) ||
                          (op_q == mxb_pkg::MXB_OP_BUSIN);
   wire logic is_wr     = (op_q == mxb_pkg::MXB_OP_XWR) ||
                          (op_q == mxb_pkg::MXB_OP_BUSOUT);
   wire logic is_fetch  = (op_q == mxb_pkg::MXB_OP_FETCH) && ext_q;
   wire logic is_xmem   = (op_q == mxb_pkg::MXB_OP_XRD) ||
                          (op_q == mxb_pkg::MXB_OP_XWR);
   wire logic is_exp    = (op_q == mxb_pkg::MXB_OP_EXP);

   // Strap caught on a clock edge, not under reset
   // [RQ8] external code select
   always_ff @(posedge ref_clk) begin
      ext_q <= external_code_select;
   end

   // Phase counter; held at phase 0 while halted in step hold
   // [RQ1] one latch pulse per cycle
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         phase_q <= '0;
      end else if (state_q == mxb_pkg::MXB_ST_STEP_HOLD) begin
         phase_q <= '0;
      end else if (last_ph) begin
         phase_q <= '0;
      end else begin
         phase_q <= phase_q + 4'h1;
      end
   end

   // [RQ14] halt after instruction
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_q <= mxb_pkg::MXB_ST_RUN;
         step_q  <= 1'b1;
      end else begin
         step_q <= single_step_n;
         case (state_q)
            mxb_pkg::MXB_ST_RUN: begin
               if (last_ph && core_instr_end && !single_step_n)
                  state_q <= mxb_pkg::MXB_ST_STEP_HOLD;
            end
            mxb_pkg::MXB_ST_STEP_HOLD: begin
               // Release on a rising single-step edge only
               if (single_step_n && !step_q)
                  state_q <= mxb_pkg::MXB_ST_RUN;
            end
            default: state_q <= mxb_pkg::MXB_ST_RUN;
         endcase
      end
   end

   // Request capture at cycle start
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         op_q      <= mxb_pkg::MXB_OP_NONE;
         pc_q      <= '0;
         addr_q    <= '0;
         exp_ctl_q <= '0;
      end else if (phase_q == mxb_pkg::PH_ALE_ON &&
                   state_q == mxb_pkg::MXB_ST_RUN) begin
         op_q      <= mxb_pkg::mxb_op_t'(core_op);
         pc_q      <= core_pc;
         addr_q    <= core_addr;
         exp_ctl_q <= core_exp_ctl;
      end
   end

   // [RQ7] output data latch
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         out_latch_q <= '0;
      end else if (phase_q == mxb_pkg::PH_ADDR_OFF && is_wr) begin
         out_latch_q <= core_wdata;
      end
   end

   // Strobes registered from phase; ALE falls while address still held
   // [RQ17] strobe polarities
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ale                 <= 1'b0;
         prog_fetch_strobe_n <= 1'b1;
         rd_n                <= 1'b1;
         wr_n                <= 1'b1;
         exp_strobe          <= 1'b0;
      end else begin
         // [RQ1] latch pulse
         ale <= (state_q == mxb_pkg::MXB_ST_RUN) &&
                in_win(phase_q + 4'h1, 4'h1, mxb_pkg::PH_ALE_OFF + 4'h1);
         // [RQ2] fetch strobe
         prog_fetch_strobe_n <= !(is_fetch && strobe_ph);
         // [RQ5] read strobe
         rd_n <= !(is_rd && strobe_ph);
         // [RQ6] write strobe
         wr_n <= !(is_wr && strobe_ph);
         // [RQ10] expander strobe
         exp_strobe <= is_exp && strobe_ph;
      end
   end

   // Bus lines drive: address in latch window, write data in strobe
   // [RQ2] low PC byte on bus
   // [RQ4] data address on bus
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         bus_lines_o  <= '0;
         bus_lines_oe <= 1'b0;
      end else if (addr_ph && (is_fetch || is_xmem)) begin
         bus_lines_oe <= 1'b1;
         bus_lines_o  <= is_fetch ? pc_q[7:0] : addr_q;
      end else if (is_wr && phase_q >= mxb_pkg::PH_ADDR_OFF) begin
         // [RQ7] latched output data; latch loads on this same edge
         bus_lines_oe <= 1'b1;
         bus_lines_o  <= (phase_q == mxb_pkg::PH_ADDR_OFF) ? core_wdata
                                                           : out_latch_q;
      end else begin
         bus_lines_oe <= 1'b0;
         bus_lines_o  <= out_latch_q;
      end
   end

   // Read capture just before the strobe rises
   // [RQ2] instruction byte read
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         core_rdata     <= '0;
         core_rdata_vld <= 1'b0;
      end else begin
         core_rdata_vld <= 1'b0;
         if (phase_q == mxb_pkg::PH_STB_OFF - 4'h1 &&
             (is_fetch || is_rd)) begin
            core_rdata     <= bus_lines_i;
            core_rdata_vld <= 1'b1;
         end else if (phase_q == mxb_pkg::PH_STB_OFF - 4'h1 && is_exp) begin
            core_rdata     <= {4'h0, port_two_i[3:0]};
            core_rdata_vld <= 1'b1;
         end
      end
   end

   // [RQ9] port latches reset to ones
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         p1_latch_q <= mxb_pkg::PORT_RESET;
         p2_latch_q <= mxb_pkg::PORT_RESET;
      end else begin
         if (port_one_wr)
            p1_latch_q <= port_one_wdata;
         if (port_two_wr)
            p2_latch_q <= port_two_wdata;
      end
   end

   // Quasi pins: pull low strongly, ones only weakly (no drive)
   // [RQ9] quasi-bidirectional ports
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         port_one_o  <= '0;
         port_one_oe <= '0;
         port_two_o  <= '0;
         port_two_oe <= '0;
      end else begin
         port_one_o  <= '0;
         port_one_oe <= ~p1_latch_q;
         port_two_o  <= '0;
         port_two_oe <= {~p2_latch_q[7:4], 4'h0};
         if (is_fetch && phase_q >= mxb_pkg::PH_ALE_ON) begin
            // [RQ3] upper PC bits on port two
            port_two_o[3:0]  <= pc_q[PC_W-1 -: 4];
            port_two_oe[3:0] <= mxb_pkg::NIB_RESET;
         end else if (is_exp && phase_q < mxb_pkg::PH_STB_ON) begin
            // [RQ10] expander control nibble before strobe
            port_two_o[3:0]  <= exp_ctl_q;
            port_two_oe[3:0] <= mxb_pkg::NIB_RESET;
         end else begin
            port_two_oe[3:0] <= ~p2_latch_q[3:0];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         // Undriven pins read high through their pull-ups
         port_one_in <= mxb_pkg::PORT_RESET;
         port_two_in <= mxb_pkg::PORT_RESET;
      end else begin
         // Pins driven low read as low; only ones-written pins act as inputs
         port_one_in <= port_one_i & p1_latch_q;
         port_two_in <= port_two_i & p2_latch_q;
      end
   end

   // [RQ11] test pin a clock output
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         clk_out_en_q <= 1'b0;
         div_q        <= '0;
         clk_out_q    <= 1'b0;
      end else begin
         if (clock_out_enable_instr)
            clk_out_en_q <= 1'b1;
         div_q <= (div_q == mxb_pkg::CLK_DIV_MAX) ? 2'h0 : div_q + 2'h1;
         if (div_q == mxb_pkg::CLK_DIV_MAX)
            clk_out_q <= !clk_out_q;
      end
   end

   // [RQ12] event counting on test pin b
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         count_en_q <= 1'b0;
         tb_q       <= 1'b0;
         event_tick <= 1'b0;
      end else begin
         if (start_event_count_instr)
            count_en_q <= 1'b1;
         else if (stop_event_count_instr)
            count_en_q <= 1'b0;
         tb_q       <= test_pin_b;
         // High-to-low transition counts one event
         event_tick <= count_en_q && tb_q && !test_pin_b;
      end
   end

   // [RQ11] [RQ12] [RQ13] jump condition sampling
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         jump_on_test_a  <= 1'b0;
         jump_on_test_b  <= 1'b0;
         jump_on_irq_pin <= 1'b0;
         irq_req         <= 1'b0;
      end else begin
         jump_on_test_a  <= clk_out_en_q ? 1'b0 : test_pin_a_i;
         jump_on_test_b  <= test_pin_b;
         jump_on_irq_pin <= !irq_pin_n;
         irq_req         <= !irq_pin_n;
      end
   end

   assign test_pin_a_o  = clk_out_q;
   assign test_pin_a_oe = clk_out_en_q;
   assign cycle_start   = (phase_q == mxb_pkg::PH_ALE_ON) &&
                          (state_q == mxb_pkg::MXB_ST_RUN);
   assign core_stall    = (state_q == mxb_pkg::MXB_ST_STEP_HOLD);
endmodule
`default_nettype wire

// ### rtl/mxb_pkg.sv
// Constants for the external memory and expander bus block
package mxb_pkg;
   // Machine cycle is fifteen states of the internal clock
   localparam int unsigned CYC_LEN     = 15;
   localparam logic [3:0]  PH_ALE_ON   = 4'h0;
   localparam logic [3:0]  PH_ALE_OFF  = 4'h3;
   localparam logic [3:0]  PH_ADDR_OFF = 4'h4;
   localparam logic [3:0]  PH_STB_ON   = 4'h5;
   localparam logic [3:0]  PH_STB_OFF  = 4'hB;
   localparam logic [3:0]  PH_LAST     = 4'hE;
   localparam logic [7:0]  PORT_RESET  = 8'hFF;
   localparam logic [3:0]  NIB_RESET   = 4'hF;
   localparam logic [1:0]  CLK_DIV_MAX = 2'h2;

   // Kinds of external cycle
   typedef enum logic [2:0] {
      MXB_OP_NONE,
      MXB_OP_FETCH,
      MXB_OP_XRD,
      MXB_OP_XWR,
      MXB_OP_BUSIN,
      MXB_OP_BUSOUT,
      MXB_OP_EXP
   } mxb_op_t;

   typedef enum logic [1:0] {
      MXB_ST_RUN,
      MXB_ST_STEP_HOLD
   } mxb_state_t;
endpackage

// ### test/mxb_ext_bus_properties.sv
// Port-level assertions for the external bus block
`timescale 1ns/1ps
`default_nettype none
module mxb_ext_bus_properties (
   // Clock and reset
   input wire logic       ref_clk,
   input wire logic       reset,
   // Pins in
   input wire logic       external_code_select,
   input wire logic       irq_pin_n,
   // Core side
   input wire logic [2:0] core_op,
   input wire logic       cycle_start,
   input wire logic       jump_on_irq_pin,
   // Strobes, bus and test pin a
   input wire logic       ale,
   input wire logic       prog_fetch_strobe_n,
   input wire logic       rd_n,
   input wire logic       wr_n,
   input wire logic [7:0] bus_lines_o,
   input wire logic       bus_lines_oe,
   input wire logic       test_pin_a_o,
   input wire logic       test_pin_a_oe
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   sequence s_ale_pulse;
      ale [*3] ##1 !ale [*8];
   endsequence
   sequence s_fetch_low;
      !prog_fetch_strobe_n [*6] ##1 prog_fetch_strobe_n;
   endsequence
   sequence s_rd_low;
      !rd_n [*6] ##1 rd_n;
   endsequence

   a_ale_on_start: assert property (cycle_start |=> $rose(ale))
      else $error("latch strobe missing after cycle start");
   a_ale_pulse_shape: assert property ($rose(ale) |-> s_ale_pulse)
      else $error("latch strobe shape wrong");
   a_addr_with_ale: assert property (cycle_start &&
      (core_op == 3'h2 || core_op == 3'h3) |=> ##1
      (ale && bus_lines_oe) [*2])
      else $error("bus not driven under latch strobe");
   a_fetch_shape: assert property ($fell(prog_fetch_strobe_n) |-> s_fetch_low)
      else $error("fetch strobe width wrong");
   a_fetch_after_ale: assert property ($fell(prog_fetch_strobe_n) |->
      $past(ale, 3) && !$past(ale, 2))
      else $error("fetch strobe out of step with latch");
   a_fetch_needs_strap: assert property ($fell(prog_fetch_strobe_n) |->
      external_code_select)
      else $error("fetch strobe with internal code");
   a_rd_shape: assert property ($fell(rd_n) |-> s_rd_low)
      else $error("read strobe width wrong");
   a_wr_data_held: assert property (!wr_n |->
      bus_lines_oe && $stable(bus_lines_o))
      else $error("write data not held");
   a_bus_free_read: assert property ((!rd_n || !prog_fetch_strobe_n) |->
      !bus_lines_oe)
      else $error("bus driven during a read");
   a_irq_follow: assert property (1'b1 |=>
      jump_on_irq_pin == !$past(irq_pin_n))
      else $error("interrupt jump flag wrong");
   a_clk_out_rate: assert property (test_pin_a_oe && $changed(test_pin_a_o)
      |=> $stable(test_pin_a_o) [*2] ##1 $changed(test_pin_a_o))
      else $error("clock out period wrong");
endmodule

bind mxb_ext_bus mxb_ext_bus_properties i_props (.ref_clk, .reset,
   .external_code_select, .irq_pin_n, .core_op, .cycle_start,
   .jump_on_irq_pin, .ale,
   .prog_fetch_strobe_n, .rd_n, .wr_n, .bus_lines_o, .bus_lines_oe,
   .test_pin_a_o, .test_pin_a_oe);
`default_nettype wire

// ### test/mxb_ext_bus_tb_top.sv
// Self-checking bench for the external bus block
`timescale 1ns/1ps
`default_nettype none
module mxb_ext_bus_tb_top;
   logic        ref_clk, reset, core_instr_end, core_rdata_vld, cycle_start;
   logic [11:0] core_pc;
   logic [2:0]  core_op;
   logic [7:0]  core_addr, core_wdata, core_rdata, port_one_in, port_two_in;
   logic [3:0]  core_exp_ctl, nib_seen;
   logic [7:0]  port_one_wdata, port_two_wdata, p1_ext, p2_ext, a_seen;
   logic [7:0]  bus_lines_i, bus_lines_o, port_one_i, port_one_o, rd_seen;
   logic [7:0]  port_one_oe, port_two_i, port_two_o, port_two_oe;
   logic [7:0]  lat_addr, wr_data;
   logic        port_one_wr, port_two_wr, clock_out_enable_instr, irq_req;
   logic        start_event_count_instr, stop_event_count_instr, core_stall;
   logic        jump_on_test_a, jump_on_test_b, jump_on_irq_pin, event_tick;
   logic        external_code_select, single_step_n, irq_pin_n, ale, rd_n;
   logic        prog_fetch_strobe_n, wr_n, exp_strobe, bus_lines_oe;
   logic        test_pin_a_i, test_pin_a_o, test_pin_a_oe, test_pin_b, tpa_ext;
   int          errors, checks_done, n_ale, n_prog_fetch_strobe, n_rd, n_wr, n_exp, n_vld;

   mxb_ext_bus #(.PC_W(12)) i_dut (.*);
   mxb_mem_model i_mem (.ref_clk, .ale, .prog_fetch_strobe_n, .rd_n, .wr_n,
      .dev_o(bus_lines_o), .dev_oe(bus_lines_oe), .bus(bus_lines_i),
      .lat_addr, .wr_data);
   // Pull-ups on the quasi-bidirectional pins
   assign port_one_i = (port_one_oe & port_one_o) | (~port_one_oe & p1_ext);
   assign port_two_i = (port_two_oe & port_two_o) | (~port_two_oe & p2_ext);
   assign test_pin_a_i = test_pin_a_oe ? test_pin_a_o : tpa_ext;

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [7:0] got, exp, input string what);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic edges(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   // Leaves the bench at the edge that enters phase 0
   task automatic sync();
      int i;
      i = 0;
      @(negedge ref_clk);
      while (cycle_start !== 1'b1 && i < 100) begin
         @(negedge ref_clk);
         i++;
      end
      if (i >= 100) begin
         errors++;
         $display("[FAIL] %0t no cycle start", $time);
         results();
      end
      repeat (15) @(posedge ref_clk);
   endtask

   task automatic op_cycle(input mxb_pkg::mxb_op_t op, input logic [11:0] pc,
                           input logic [7:0] ad, wd);
      sync();
      core_op <= op;
      core_pc <= pc;
      core_addr <= ad;
      core_wdata <= wd;
      {n_ale, n_prog_fetch_strobe, n_rd, n_wr, n_exp, n_vld} = '0;
      for (int i = 0; i < 16; i++) begin
         if (i > 0) @(posedge ref_clk);
         if (i == 15) core_op <= mxb_pkg::MXB_OP_NONE;
         @(negedge ref_clk);
         if (ale === 1'b1) begin
            n_ale++;
            a_seen = bus_lines_i;
            nib_seen = port_two_i[3:0];
         end
         if (core_rdata_vld === 1'b1) begin
            n_vld++;
            rd_seen = core_rdata;
         end
         n_prog_fetch_strobe += int'(prog_fetch_strobe_n === 1'b0);
         n_rd += int'(rd_n === 1'b0);
         n_wr += int'(wr_n === 1'b0);
         n_exp += int'(exp_strobe === 1'b1);
      end
   endtask

   task automatic t_reset();
      chk({ale, exp_strobe, bus_lines_oe}, 8'h00, "reset low");
      chk({prog_fetch_strobe_n, rd_n, wr_n}, 8'h07, "reset high");
      chk(port_one_in, 8'hFF, "port one");
      chk(port_two_in, 8'hFF, "port two");
      $display("test reset done");
   endtask

   task automatic t_fetch();
      @(posedge ref_clk);
      external_code_select <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         op_cycle(mxb_pkg::MXB_OP_FETCH, k ? 12'h3FE : 12'hA53, 8'h00, 8'h00);
         chk(8'(n_ale), 8'h03, "ale count");
         chk(a_seen, k ? 8'hFE : 8'h53, "pc low");
         chk(nib_seen, k ? 4'h3 : 4'hA, "pc high");
         chk(8'(n_prog_fetch_strobe), 8'h06, "fetch width");
         chk(rd_seen, k ? 8'hA4 : 8'h09, "code byte");
      end
      @(posedge ref_clk);
      external_code_select <= 1'b0;
      op_cycle(mxb_pkg::MXB_OP_FETCH, 12'h123, 8'h00, 8'h00);
      chk(8'(n_prog_fetch_strobe), 8'h00, "internal fetch");
      chk(8'(n_ale), 8'h03, "ale idle");
      $display("test fetch done");
   endtask

   task automatic t_data();
      op_cycle(mxb_pkg::MXB_OP_XRD, 12'h000, 8'h4C, 8'h00);
      chk(a_seen, 8'h4C, "rd addr");
      chk(8'(n_rd), 8'h06, "rd width");
      chk(rd_seen, 8'h16, "rd data");
      op_cycle(mxb_pkg::MXB_OP_XWR, 12'h000, 8'hC3, 8'h96);
      chk(lat_addr, 8'hC3, "wr addr");
      chk(8'(n_wr), 8'h06, "wr width");
      chk(wr_data, 8'h96, "wr data");
      op_cycle(mxb_pkg::MXB_OP_BUSIN, 12'h000, 8'h00, 8'h00);
      chk(8'(n_rd), 8'h06, "bus in");
      op_cycle(mxb_pkg::MXB_OP_BUSOUT, 12'h000, 8'h00, 8'h69);
      chk(8'(n_wr), 8'h06, "bus out");
      chk(wr_data, 8'h69, "bus out data");
      @(posedge ref_clk);
      core_exp_ctl <= 4'h9;
      op_cycle(mxb_pkg::MXB_OP_EXP, 12'h000, 8'h00, 8'h00);
      chk(8'(n_exp > 0), 8'h01, "exp strobe");
      chk(8'(nib_seen), 8'h09, "exp nibble");
      chk(8'(n_rd + n_wr + n_prog_fetch_strobe), 8'h00, "exp only");
      $display("test data done");
   endtask

   task automatic t_pins();
      int k;
      logic tpa_prev;
      @(posedge ref_clk);
      p1_ext <= 8'h3C;
      irq_pin_n <= 1'b0;
      tpa_ext <= 1'b1;
      test_pin_b <= 1'b1;
      start_event_count_instr <= 1'b1;
      @(posedge ref_clk);
      start_event_count_instr <= 1'b0;
      port_one_wr <= 1'b1;
      port_one_wdata <= 8'h0F;
      @(posedge ref_clk);
      port_one_wr <= 1'b0;
      test_pin_b <= 1'b0;
      clock_out_enable_instr <= 1'b1;
      @(posedge ref_clk);
      clock_out_enable_instr <= 1'b0;
      k = 0;
      repeat (6) begin
         @(negedge ref_clk);
         k += int'(event_tick === 1'b1);
      end
      chk(8'(k), 8'h01, "event tick");
      chk(port_one_in, 8'h0C, "port read");
      chk(jump_on_irq_pin, 8'h01, "irq jump");
      chk(irq_req, 8'h01, "irq req");
      chk(test_pin_a_oe, 8'h01, "clock out on");
      k = 0;
      tpa_prev = test_pin_a_o;
      repeat (12) begin
         @(negedge ref_clk);
         k += int'(test_pin_a_o !== tpa_prev);
         tpa_prev = test_pin_a_o;
      end
      chk(8'(k), 8'h04, "clock out toggles");
      chk(8'(jump_on_test_a), 8'h00, "test a masked");
      @(posedge ref_clk);
      irq_pin_n <= 1'b1;
      stop_event_count_instr <= 1'b1;
      test_pin_b <= 1'b1;
      @(posedge ref_clk);
      stop_event_count_instr <= 1'b0;
      test_pin_b <= 1'b0;
      k = 0;
      repeat (6) begin
         @(negedge ref_clk);
         k += int'(event_tick === 1'b1);
      end
      chk(8'(k), 8'h00, "no tick stopped");
      chk({jump_on_irq_pin, irq_req, jump_on_test_b}, 8'h00, "pins off");
      $display("test pins done");
   endtask

   task automatic t_step();
      int i;
      @(posedge ref_clk);
      core_instr_end <= 1'b1;
      single_step_n <= 1'b0;
      i = 0;
      while (core_stall !== 1'b1 && i < 40) begin
         @(negedge ref_clk);
         i++;
      end
      chk(core_stall, 8'h01, "step halt");
      i = 0;
      repeat (20) begin
         @(negedge ref_clk);
         i += int'(cycle_start === 1'b1);
      end
      chk(8'(i), 8'h00, "held still");
      @(posedge ref_clk);
      single_step_n <= 1'b1;
      core_instr_end <= 1'b0;
      edges(20);
      chk(core_stall, 8'h00, "step resume");
      $display("test step done");
   endtask

   initial begin
      {reset, single_step_n, irq_pin_n, test_pin_b, tpa_ext} = 5'h1F;
      {core_pc, core_op, core_addr, core_wdata, core_exp_ctl} = '0;
      {core_instr_end, port_one_wr, port_two_wr, clock_out_enable_instr} = '0;
      {start_event_count_instr, stop_event_count_instr} = '0;
      {port_one_wdata, port_two_wdata, external_code_select} = '0;
      {p1_ext, p2_ext} = 16'hFFFF;
      {errors, checks_done} = '0;
      edges(4);
      t_reset();
      @(posedge ref_clk);
      reset <= 1'b0;
      t_fetch();
      t_data();
      t_pins();
      t_step();
      results();
   end
endmodule
`default_nettype wire

// ### test/mxb_mem_model.sv
// External memory with address latch, seen from the bus lines
`timescale 1ns/1ps
`default_nettype none
module mxb_mem_model (
   // Strobes
   input wire logic        ref_clk,
   input wire logic        ale,
   input wire logic        prog_fetch_strobe_n,
   input wire logic        rd_n,
   input wire logic        wr_n,
   // Bus lines
   input wire logic [7:0]  dev_o,
   input wire logic        dev_oe,
   output logic [7:0]      bus,
   // Captured values
   output logic [7:0]      lat_addr,
   output logic [7:0]      wr_data
);
   logic [7:0] last_q;
   logic       mem_oe;
   // low byte latched as the strobe falls
   always @(negedge ale) lat_addr <= bus;
   // data taken at the end of the write strobe
   always @(posedge wr_n) wr_data <= bus;
   // drives only while the fetch or read strobe is low
   assign mem_oe = !prog_fetch_strobe_n || !rd_n;
   // Released lines drift so stale data cannot pass
   assign bus = dev_oe ? dev_o : mem_oe ? (lat_addr ^ 8'h5A) : ~last_q;
   always_ff @(posedge ref_clk) last_q <= bus;
endmodule
`default_nettype wire
